// ===== hdl/asr_readout.sv
// Sample status and output byte registers of a three-axis accelerometer.
// Assumes the serial slave decodes addresses and byte reads on clk and
// hands over single-cycle strobes; sample and FIFO head come from clk logic.
// Function
// - Set combined overwrite flag when a new sample lands before previous set read.
// - Clear combined overwrite only after high bytes of all active axes read.
// - Set an axis overwrite flag when its unread sample is replaced.
// - Clear an axis overwrite flag whenever that axis high byte is read.
// - Set combined ready flag when any enabled axis has a new sample.
// - Clear combined ready only after high bytes of all enabled axes read.
// - Clear an axis ready flag when that axis high byte is read and no new sample lands in the same cycle.
// - All eight status flags are zero after reset.
// - Samples are 14-bit; high byte bits 13..6, low byte bits 5..0 then zeros.
// - Output bytes sit at consecutive addresses X, Y, Z high then low.
// - Fast read makes auto-increment skip the low byte registers.
// - Low byte readable only right after its high byte; no random low reads.
// - High then low read of an axis return the same sample.
// - FIFO off: output bytes show the current sample.
// - FIFO on: output bytes come from the FIFO head sample.
// - Address zero gives sample status with FIFO off, FIFO status with it on.
// - Stop condition discards the stored auto-increment address.
`timescale 1ns/1ps
`include "asr_map.svh"

module asr_readout (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              sample_valid,
   input  wire asr_pkg::asr_sample_t sample_x,
   input  wire asr_pkg::asr_sample_t sample_y,
   input  wire asr_pkg::asr_sample_t sample_z,
   input  wire asr_pkg::asr_mask_t   axis_en,
   input  wire logic [1:0]        fifo_mode_sel,
   input  wire logic              fast_read_sel,
   input  wire asr_pkg::asr_sample_t fifo_head_x,
   input  wire asr_pkg::asr_sample_t fifo_head_y,
   input  wire asr_pkg::asr_sample_t fifo_head_z,
   input  wire asr_pkg::asr_byte_t   fifo_status,
   input  wire logic              addr_load,
   input  wire asr_pkg::asr_byte_t   addr_in,
   input  wire logic              rd_strobe,
   input  wire logic              stop_det,
   output      asr_pkg::asr_byte_t   rd_data,
   output      logic              rd_valid,
   output      asr_pkg::asr_byte_t   status_flags
);
   import asr_pkg::*;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   // Per-axis instances
   asr_axis_if  ax_if [`ASR_AXES] ();
   asr_sample_t samp_in [`ASR_AXES];
   asr_sample_t head_in [`ASR_AXES];
   asr_sample_t src     [`ASR_AXES];
   asr_mask_t   axis_new;
   asr_mask_t   high_hit;
   asr_mask_t   ready_v;
   asr_mask_t   ow_v;

   assign samp_in[0] = sample_x;
   assign samp_in[1] = sample_y;
   assign samp_in[2] = sample_z;
   assign head_in[0] = fifo_head_x;
   assign head_in[1] = fifo_head_y;
   assign head_in[2] = fifo_head_z;

   logic fifo_on;
   assign fifo_on = (fifo_mode_sel != `ASR_FIFO_OFF);

   genvar gi;
   generate
      for (gi = 0; gi < `ASR_AXES; gi++) begin : g_axis
         assign axis_new[gi]             = sample_valid & axis_en[gi];
         assign ax_if[gi].new_sample     = axis_new[gi];
         assign ax_if[gi].sample_in      = samp_in[gi];
         assign ax_if[gi].high_read      = high_hit[gi];
         assign ready_v[gi]              = ax_if[gi].ready;
         assign ow_v[gi]                 = ax_if[gi].overwrite;
         // FIFO head replaces the live sample while the FIFO is on
         assign src[gi] = fifo_on ? head_in[gi] : ax_if[gi].sample_q;
         asr_axis u_axis (
            .clk    (clk),
            .arst_n (arst_n),
            .ax     (ax_if[gi])
         );
      end
   endgenerate

   // Access state
   asr_byte_t   addr;
   asr_axis_t   last_high;
   logic [`ASR_LOW_BITS-1:0] shadow_low;
   logic        xyz_rdy;
   logic        xyz_ow;
   asr_mask_t   ow_pend;
   asr_byte_t   rd_q;
   logic        rd_v_q;

   asr_byte_t   next_addr;
   asr_axis_t   next_last_high;
   logic [`ASR_LOW_BITS-1:0] next_shadow_low;
   logic        next_xyz_rdy;
   logic        next_xyz_ow;
   asr_mask_t   next_ow_pend;
   asr_byte_t   next_rd_q;

   asr_byte_t   cur;
   asr_byte_t   status_byte;
   asr_axis_t   hi_axis;
   asr_axis_t   lo_axis;
   logic        low_ok;
   logic [`ASR_LOW_BITS-1:0] hi_low_bits;
   asr_mask_t   ow_set;
   logic        rdy_any_left;

   function automatic asr_byte_t asr_step(input asr_byte_t a, input logic fast);
      asr_byte_t n;
      n = 8'(a + `ASR_STEP);
      if (fast) begin
         // Fast burst is status then three high bytes, then back to status
         if (a == `ASR_X_HIGH_ADDR || a == `ASR_Y_HIGH_ADDR) begin
            n = 8'(a + `ASR_FAST_STEP);
         end else if (a == `ASR_Z_HIGH_ADDR) begin
            n = `ASR_STATUS_ADDR;
         end
      end
      return n;
   endfunction : asr_step

   function automatic asr_axis_t asr_decode(input asr_byte_t a, input logic high);
      asr_axis_t r;
      r = ASR_AX_NONE;
      unique case (a)
         `ASR_X_HIGH_ADDR: r = high ? ASR_AX_X : ASR_AX_NONE;
         `ASR_X_LOW_ADDR:  r = high ? ASR_AX_NONE : ASR_AX_X;
         `ASR_Y_HIGH_ADDR: r = high ? ASR_AX_Y : ASR_AX_NONE;
         `ASR_Y_LOW_ADDR:  r = high ? ASR_AX_NONE : ASR_AX_Y;
         `ASR_Z_HIGH_ADDR: r = high ? ASR_AX_Z : ASR_AX_NONE;
         `ASR_Z_LOW_ADDR:  r = high ? ASR_AX_NONE : ASR_AX_Z;
         default:          r = ASR_AX_NONE;
      endcase
      return r;
   endfunction : asr_decode

   // Address decode and status assembly
   always_comb begin
      // A repeated start takes the new address in the same cycle as the read
      cur         = addr_load ? addr_in : addr;
      hi_axis     = asr_decode(cur, 1'b1);
      lo_axis     = asr_decode(cur, 1'b0);
      low_ok      = (lo_axis != ASR_AX_NONE) && (lo_axis == last_high);
      high_hit    = '0;
      hi_low_bits = '0;
      if (rd_strobe && hi_axis != ASR_AX_NONE) begin
         high_hit[hi_axis] = 1'b1;
         hi_low_bits       = src[hi_axis][`ASR_LOW_BITS-1:0];
      end
      status_byte = {xyz_ow, ow_v[2], ow_v[1], ow_v[0],
                     xyz_rdy, ready_v[2], ready_v[1], ready_v[0]};
   end

   // Combined flags
   always_comb begin
      ow_set       = axis_new & ready_v & ~high_hit;
      // Pending high reads of active axes; a fresh overwrite re-arms them
      next_ow_pend = (ow_pend & ~high_hit) | ((|ow_set) ? axis_en : '0);
      next_xyz_ow  = (|ow_set) | (xyz_ow & (|next_ow_pend));
      rdy_any_left = |(ready_v & ~high_hit);
      next_xyz_rdy = (|axis_new) | (xyz_rdy & rdy_any_left);
   end

   // Address, low byte latch and read data
   always_comb begin
      next_addr       = addr;
      next_last_high  = last_high;
      next_shadow_low = shadow_low;
      next_rd_q       = rd_q;
      if (addr_load) begin
         next_addr = addr_in;
      end
      if (rd_strobe) begin
         next_addr      = asr_step(cur, fast_read_sel);
         next_last_high = hi_axis;
         if (cur == `ASR_STATUS_ADDR) begin
            next_rd_q = fifo_on ? fifo_status : status_byte;
         end else if (hi_axis != ASR_AX_NONE) begin
            next_rd_q = src[hi_axis][`ASR_SAMPLE_W-1:`ASR_LOW_BITS];
            // Low bits frozen here so a new sample cannot split the pair
            next_shadow_low = hi_low_bits;
         end else if (low_ok) begin
            next_rd_q = {shadow_low, `ASR_LOW_PAD};
         end else begin
            // Random low reads and foreign addresses answer zero
            next_rd_q = `ASR_BYTE_ZERO;
         end
      end
      if (stop_det) begin
         next_addr      = `ASR_ADDR_RESET;
         next_last_high = ASR_AX_NONE;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr       <= `ASR_ADDR_RESET;
         last_high  <= ASR_AX_NONE;
         shadow_low <= '0;
         xyz_rdy    <= 1'b0;
         xyz_ow     <= 1'b0;
         ow_pend    <= `ASR_FLAG_RESET;
         rd_q       <= `ASR_BYTE_ZERO;
         rd_v_q     <= 1'b0;
      end else begin
         addr       <= next_addr;
         last_high  <= next_last_high;
         shadow_low <= next_shadow_low;
         xyz_rdy    <= next_xyz_rdy;
         xyz_ow     <= next_xyz_ow;
         ow_pend    <= next_ow_pend;
         rd_q       <= next_rd_q;
         rd_v_q     <= rd_strobe;
      end
   end

   assign rd_data      = rd_q;
   assign rd_valid     = rd_v_q;
   assign status_flags = status_byte;

   xyz_ow_set_a : assert property (
      (|ow_set) |=> xyz_ow && status_flags[`ASR_XYZ_OW_BIT])
      else $error("combined overwrite not set on lost sample");

   xyz_ow_hold_a : assert property (
      xyz_ow && (|(ow_pend & ~high_hit)) |=> xyz_ow)
      else $error("combined overwrite cleared before all high reads");

   xyz_rdy_set_a : assert property (
      (|axis_new) |=> xyz_rdy ##0 (|status_flags[`ASR_XYZ_RDY_BIT:`ASR_RDY_LSB]))
      else $error("combined ready not set on new sample");

   xyz_rdy_hold_a : assert property (
      xyz_rdy && (|(ready_v & ~high_hit)) |=> xyz_rdy)
      else $error("combined ready cleared with unread axes");

   flags_clear_a : assert property (
      $fell(ready_v[0]) |-> $past(high_hit[0]))
      else $error("x ready cleared without a high byte read");

   low_pair_a : assert property (
      (rd_strobe && hi_axis != ASR_AX_NONE && !stop_det) ##1 (rd_strobe && low_ok)
      |=> rd_data[7:2] == $past(hi_low_bits, 2))
      else $error("low byte not from the same sample as its high byte");

   random_low_a : assert property (
      rd_strobe && lo_axis != ASR_AX_NONE && !low_ok |=> rd_data == `ASR_BYTE_ZERO)
      else $error("random low byte read returned data");

   fast_skip_a : assert property (
      rd_strobe && fast_read_sel && !stop_det && cur == `ASR_X_HIGH_ADDR
      |=> addr == `ASR_Y_HIGH_ADDR)
      else $error("fast read did not skip the low byte");

   burst_step_a : assert property (
      rd_strobe && !fast_read_sel && !stop_det && cur == `ASR_Y_HIGH_ADDR
      |=> addr == `ASR_Y_LOW_ADDR ##0 rd_valid)
      else $error("plain burst did not step to the next byte");

   status_src_a : assert property (
      rd_strobe && cur == `ASR_STATUS_ADDR && fifo_on |=> rd_data == $past(fifo_status))
      else $error("address zero not FIFO status with FIFO on");

   stop_clear_a : assert property (
      stop_det |=> addr == `ASR_ADDR_RESET && last_high == ASR_AX_NONE)
      else $error("stop did not discard the burst address");

   answer_pulse_a : assert property (
      1'b1 |=> rd_valid == $past(rd_strobe))
      else $error("read answer not one cycle after the read");

   status_live_a : assert property (
      rd_strobe && cur == `ASR_STATUS_ADDR && !fifo_on |=> rd_data == $past(status_flags))
      else $error("address zero not sample status with FIFO off");

   status_quiet_a : assert property (
      rd_strobe && cur == `ASR_STATUS_ADDR && !sample_valid
      |=> status_flags == $past(status_flags))
      else $error("status read changed the flags");

   low_pad_a : assert property (
      rd_strobe && low_ok |=> rd_data[1:0] == `ASR_LOW_PAD)
      else $error("low byte padding bits not zero");

   live_src_a : assert property (
      rd_strobe && !fifo_on && hi_axis == ASR_AX_X
      |=> rd_data == $past(ax_if[0].sample_q[`ASR_SAMPLE_W-1:`ASR_LOW_BITS]))
      else $error("x high byte not from the current sample");

   fifo_src_a : assert property (
      rd_strobe && fifo_on && hi_axis == ASR_AX_X
      |=> rd_data == $past(fifo_head_x[`ASR_SAMPLE_W-1:`ASR_LOW_BITS]))
      else $error("x high byte not from the FIFO head");

   z_clear_a : assert property (
      high_hit[2] && !axis_new[2] |=> !ow_v[2] && !ready_v[2])
      else $error("z flags not cleared by its high byte read");

endmodule : asr_readout

// ===== hdl/asr_map.svh
// Address map, field positions, reset values and widths of the sample readout block.
// Included by the package and by the readout top; definitions only.
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH

// Register offsets on the serial register port
`define ASR_STATUS_ADDR    8'h00
`define ASR_X_HIGH_ADDR    8'h01
`define ASR_X_LOW_ADDR     8'h02
`define ASR_Y_HIGH_ADDR    8'h03
`define ASR_Y_LOW_ADDR     8'h04
`define ASR_Z_HIGH_ADDR    8'h05
`define ASR_Z_LOW_ADDR     8'h06

// Auto-increment steps: plain and fast read (low bytes skipped)
`define ASR_STEP           8'h01
`define ASR_FAST_STEP      8'h02

// Sample layout: 14-bit two's complement, high byte bits 13..6
`define ASR_SAMPLE_W       14
`define ASR_LOW_BITS       6
`define ASR_LOW_PAD        2'b00

// Status byte field positions
`define ASR_XYZ_OW_BIT     7
`define ASR_OW_LSB         4
`define ASR_XYZ_RDY_BIT    3
`define ASR_RDY_LSB        0

// Reset values and fixed answers
`define ASR_FLAG_RESET     3'h0
`define ASR_ADDR_RESET     8'h00
`define ASR_BYTE_ZERO      8'h00
`define ASR_FIFO_OFF       2'b00
`define ASR_AXES           3

`endif

// ===== hdl/asr_pkg.sv
// Types shared by the sample readout block and its per-axis flag module.
// Assumes asr_map.svh is on the include path.
`include "asr_map.svh"

package asr_pkg;

   typedef logic [`ASR_SAMPLE_W-1:0] asr_sample_t;
   typedef logic [7:0]               asr_byte_t;
   typedef logic [`ASR_AXES-1:0]     asr_mask_t;

   // Axis whose high byte was read last, or none
   typedef enum logic [1:0] {
      ASR_AX_X    = 2'b00,
      ASR_AX_Y    = 2'b01,
      ASR_AX_Z    = 2'b10,
      ASR_AX_NONE = 2'b11
   } asr_axis_t;

endpackage : asr_pkg

// ===== hdl/asr_axis_if.sv
// Signals between the readout top and one per-axis flag and sample module.
// Assumes asr_pkg is compiled first.
`timescale 1ns/1ps

interface asr_axis_if;
   import asr_pkg::*;

   logic        new_sample;
   asr_sample_t sample_in;
   logic        high_read;
   logic        ready;
   logic        overwrite;
   asr_sample_t sample_q;

   modport axis (
      input  new_sample,
      input  sample_in,
      input  high_read,
      output ready,
      output overwrite,
      output sample_q
   );

   modport ctrl (
      output new_sample,
      output sample_in,
      output high_read,
      input  ready,
      input  overwrite,
      input  sample_q
   );

endinterface : asr_axis_if

// ===== hdl/asr_axis.sv
// One axis: holds the latest sample and its ready and overwrite flags.
// Assumes new_sample and high_read are one-cycle pulses on clk.
`timescale 1ns/1ps

module asr_axis (
   input wire logic clk,
   input wire logic arst_n,
   asr_axis_if.axis ax
);
   import asr_pkg::*;

   logic        ready;
   logic        overwrite;
   asr_sample_t sample_q;
   logic        next_ready;
   logic        next_overwrite;
   asr_sample_t next_sample;
   logic        ow_set;

   always_comb begin
      next_sample = ax.new_sample ? ax.sample_in : sample_q;
      // A read in the same cycle retrieves the old sample, so no overwrite
      ow_set         = ax.new_sample & ready & ~ax.high_read;
      next_overwrite = ow_set | (overwrite & ~ax.high_read);
      // Set wins over the clear of a coincident read
      next_ready     = ax.new_sample | (ready & ~ax.high_read);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ready     <= 1'b0;
         overwrite <= 1'b0;
         sample_q  <= '0;
      end else begin
         ready     <= next_ready;
         overwrite <= next_overwrite;
         sample_q  <= next_sample;
      end
   end

   assign ax.ready     = ready;
   assign ax.overwrite = overwrite;
   assign ax.sample_q  = sample_q;

   ow_axis_set_a : assert property (@(posedge clk) disable iff (!arst_n)
      ax.new_sample && ready && !ax.high_read |=> overwrite && ready)
      else $error("axis overwrite flag not set on lost sample");

   ow_axis_clear_a : assert property (@(posedge clk) disable iff (!arst_n)
      ax.high_read && !ax.new_sample |=> !overwrite && !ready)
      else $error("axis flags not cleared by high byte read");

   rdy_axis_set_a : assert property (@(posedge clk) disable iff (!arst_n)
      ax.new_sample |=> ready && sample_q == $past(ax.sample_in))
      else $error("axis ready or sample not taken on new sample");

endmodule : asr_axis

// ===== sim/asr_host.sv
// Host model: issues register reads through the serial slave strobes.
// Assumes asr_pkg is compiled first; drives at the falling edge of clk.
`timescale 1ns/1ps

module asr_host (
   input  wire logic               clk,
   output      logic               addr_load,
   output      asr_pkg::asr_byte_t addr_in,
   output      logic               rd_strobe,
   output      logic               stop_det,
   input  wire asr_pkg::asr_byte_t rd_data,
   input  wire logic               rd_valid
);
   import asr_pkg::*;

   asr_byte_t got [8];
   asr_byte_t n_bad;

   initial begin
      addr_load = 1'b0;
      addr_in   = 8'h00;
      rd_strobe = 1'b0;
      stop_det  = 1'b0;
      n_bad     = 8'h00;
   end

   // Back-to-back strobes; a stop may ride on the last one. The address loads with the first strobe only
   task automatic burst(input logic ld, input asr_byte_t a, input int n, input logic stp);
      for (int i = 0; i <= n; i++) begin
         @(negedge clk);
         if (i > 0) begin
            if (rd_valid !== 1'b1)
               n_bad++;
            got[i-1] = rd_data;
         end
         rd_strobe = (i < n);
         addr_load = ld && (i == 0);
         // Released address lines toggle so a stale value never looks valid
         addr_in   = (ld && i == 0) ? a : ~addr_in;
         stop_det  = stp && (i == n - 1);
      end
   endtask : burst

endmodule : asr_host

// ===== sim/asr_readout_tb_top.sv
// Self-checking bench of the sample status and output byte registers.
// Assumes asr_pkg and asr_host are compiled first; inputs change at falling edges.
`timescale 1ns/1ps

module asr_readout_tb_top;
   import asr_pkg::*;

   logic        clk, arst_n, sample_valid, fast_read_sel;
   logic        addr_load, rd_strobe, stop_det, rd_valid;
   asr_sample_t sample_x, sample_y, sample_z, fifo_head_x, fifo_head_y, fifo_head_z;
   asr_mask_t   axis_en;
   logic [1:0]  fifo_mode_sel;
   asr_byte_t   fifo_status, addr_in, rd_data, status_flags;
   asr_sample_t v [3];
   int          n_mismatch = 0;
   int          tests_run  = 0;

   asr_readout asr_readout_i (.clk(clk), .arst_n(arst_n), .sample_valid(sample_valid),
      .sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .axis_en(axis_en),
      .fifo_mode_sel(fifo_mode_sel), .fast_read_sel(fast_read_sel),
      .fifo_head_x(fifo_head_x), .fifo_head_y(fifo_head_y), .fifo_head_z(fifo_head_z),
      .fifo_status(fifo_status), .addr_load(addr_load), .addr_in(addr_in),
      .rd_strobe(rd_strobe), .stop_det(stop_det), .rd_data(rd_data),
      .rd_valid(rd_valid), .status_flags(status_flags));

   asr_host asr_host_i (.clk(clk), .addr_load(addr_load), .addr_in(addr_in),
      .rd_strobe(rd_strobe), .stop_det(stop_det), .rd_data(rd_data), .rd_valid(rd_valid));

   always #12.5 clk = ~clk;

   function automatic asr_byte_t hi(input asr_sample_t s);
      return s[13:6];
   endfunction : hi

   function automatic asr_byte_t lo(input asr_sample_t s);
      return {s[5:0], 2'b00};
   endfunction : lo

   task automatic chk(input string what, input asr_byte_t seen, input asr_byte_t exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic smp();
      @(negedge clk);
      sample_valid = 1'b1;
      sample_x     = v[0];
      sample_y     = v[1];
      sample_z     = v[2];
      @(negedge clk);
      sample_valid = 1'b0;
      sample_x     = ~v[0];
      sample_y     = ~v[1];
      sample_z     = ~v[2];
   endtask : smp

   task automatic t_basic();
      chk("reset status", status_flags, 8'h00);
      v = '{14'h1A5C, 14'h2301, 14'h0FF3};
      smp();
      chk("ready set", status_flags, 8'h0F);
      asr_host_i.burst(1'b1, 8'h00, 7, 1'b1);
      chk("burst status", asr_host_i.got[0], 8'h0F);
      for (int k = 0; k < 3; k++) begin
         chk("burst high", asr_host_i.got[1+2*k], hi(v[k]));
         chk("burst low", asr_host_i.got[2+2*k], lo(v[k]));
      end
      chk("ready cleared", status_flags, 8'h00);
      $display("test basic done");
   endtask : t_basic

   task automatic t_overwrite();
      v = '{14'h3FFF, 14'h0000, 14'h2000};
      smp();
      smp();
      chk("overwrite set", status_flags, 8'hFF);
      asr_host_i.burst(1'b1, 8'h00, 1, 1'b1);
      chk("status read", asr_host_i.got[0], 8'hFF);
      chk("status kept", status_flags, 8'hFF);
      asr_host_i.burst(1'b1, 8'h01, 1, 1'b1);
      chk("x high read", status_flags, 8'hEE);
      asr_host_i.burst(1'b1, 8'h03, 1, 1'b1);
      asr_host_i.burst(1'b1, 8'h05, 1, 1'b1);
      chk("all highs read", status_flags, 8'h00);
      $display("test overwrite done");
   endtask : t_overwrite

   task automatic t_latch();
      asr_sample_t a0;
      v = '{14'h15A7, 14'h0C3D, 14'h3210};
      a0 = v[0];
      smp();
      asr_host_i.burst(1'b1, 8'h01, 1, 1'b0);
      chk("x high", asr_host_i.got[0], hi(a0));
      v = '{14'h2AD8, 14'h13C2, 14'h0DEF};
      smp();
      asr_host_i.burst(1'b0, 8'h00, 1, 1'b1);
      chk("x low same sample", asr_host_i.got[0], lo(a0));
      asr_host_i.burst(1'b1, 8'h02, 1, 1'b1);
      chk("random low", asr_host_i.got[0], 8'h00);
      asr_host_i.burst(1'b0, 8'h00, 1, 1'b1);
      chk("addr after stop", asr_host_i.got[0], 8'hEF);
      asr_host_i.burst(1'b1, 8'h01, 5, 1'b1);
      chk("latch cleanup", status_flags, 8'h00);
      $display("test latch done");
   endtask : t_latch

   task automatic t_fast();
      fast_read_sel = 1'b1;
      v = '{14'h0123, 14'h3ABC, 14'h1F00};
      smp();
      asr_host_i.burst(1'b1, 8'h00, 5, 1'b1);
      chk("fast status", asr_host_i.got[0], 8'h0F);
      for (int k = 0; k < 3; k++)
         chk("fast high", asr_host_i.got[1+k], hi(v[k]));
      chk("fast wrap", asr_host_i.got[4], 8'h00);
      fast_read_sel = 1'b0;
      $display("test fast done");
   endtask : t_fast

   task automatic t_fifo();
      fifo_head_x = 14'h2B6D;
      fifo_head_y = 14'h1493;
      for (int m = 1; m < 4; m++) begin
         fifo_mode_sel = m[1:0];
         fifo_status   = 8'hA0 + m[7:0];
         asr_host_i.burst(1'b1, 8'h00, 6, 1'b1);
         chk("fifo status", asr_host_i.got[0], fifo_status);
         chk("fifo x high", asr_host_i.got[1], hi(fifo_head_x));
         chk("fifo x low", asr_host_i.got[2], lo(fifo_head_x));
         chk("fifo y high", asr_host_i.got[3], hi(fifo_head_y));
         chk("fifo y low", asr_host_i.got[4], lo(fifo_head_y));
         chk("fifo z high", asr_host_i.got[5], hi(fifo_head_z));
      end
      fifo_mode_sel = 2'b00;
      $display("test fifo done");
   endtask : t_fifo

   task automatic t_axis_en();
      axis_en = 3'b011;
      v = '{14'h0AAA, 14'h1555, 14'h3333};
      smp();
      chk("z disabled", status_flags, 8'h0B);
      asr_host_i.burst(1'b1, 8'h01, 3, 1'b1);
      chk("y high", asr_host_i.got[2], hi(v[1]));
      chk("enabled read", status_flags, 8'h00);
      axis_en = 3'b111;
      $display("test axis enable done");
   endtask : t_axis_en

   // Mid-run reset with flags and read data set; everything must come back clean
   task automatic t_reset();
      v = '{14'h2468, 14'h1357, 14'h3C3C};
      smp();
      smp();
      chk("before reset", status_flags, 8'hFF);
      arst_n = 1'b0;
      @(negedge clk);
      chk("reset status", status_flags, 8'h00);
      chk("reset data", rd_data, 8'h00);
      arst_n = 1'b1;
      @(negedge clk);
      chk("after release", status_flags, 8'h00);
      smp();
      asr_host_i.burst(1'b0, 8'h00, 1, 1'b1);
      chk("addr after reset", asr_host_i.got[0], 8'h0F);
      $display("test reset done");
   endtask : t_reset

   task automatic wrap_up();
      chk("answer valid", asr_host_i.n_bad, 8'h00);
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end

   initial begin
      clk           = 1'b0;
      arst_n        = 1'b0;
      sample_valid  = 1'b0;
      fast_read_sel = 1'b0;
      sample_x      = 14'h0000;
      sample_y      = 14'h0000;
      sample_z      = 14'h0000;
      fifo_head_x   = 14'h0000;
      fifo_head_y   = 14'h0000;
      fifo_head_z   = 14'h0ABC;
      axis_en       = 3'b111;
      fifo_mode_sel = 2'b00;
      fifo_status   = 8'h00;
      repeat (4) @(negedge clk);
      arst_n = 1'b1;
      t_basic();
      t_overwrite();
      t_latch();
      t_fast();
      t_fifo();
      t_axis_en();
      t_reset();
      wrap_up();
   end

endmodule : asr_readout_tb_top
